// >>> verilog/alu_and_unit.sv
// Accumulator AND unit: word, double, bit-run and stack-top conjunctions.
// Assumes word memory, bit memory and stack answer in the same cycle as a request.
//
// Contract
// - Single-word AND: low 16 accumulator bits AND one memory word.
// - Single-word AND sets zero flag when accumulator result is zero.
// - Flags hold only until a later flag-writing operation overwrites them.
// - Double AND: full 32 bits with two memory words or an immediate.
// - Double, run and stack AND set zero flag on zero 32-bit result.
// - Double, run and stack AND set negative flag on negative result.
// - Result counts as negative exactly when its top bit is one.
// - Run AND gathers 1 to 32 consecutive discrete bits from start address.
// - Stack AND combines accumulator with first stack level.
// - Stack AND discards first level, deeper levels move up one.
// - Every stack level holds a full 32-bit value.
module alu_and_unit
   import alu_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic [2:0] i_op,
   input wire logic [15:0] i_addr,
   input wire logic [31:0] i_imm,
   input wire logic [5:0] i_count,
   input wire logic i_load,
   input wire logic [31:0] i_load_value,
   input wire logic [15:0] i_mem_rdata,
   input wire logic i_bit_rdata,
   input wire logic [31:0] i_stack_top,
   output logic o_busy,
   output logic o_done,
   output logic [31:0] o_acc,
   output logic o_zero_result_flag,
   output logic o_negative_result_flag,
   output logic o_mem_rd,
   output logic [15:0] o_mem_addr,
   output logic o_bit_rd,
   output logic [15:0] o_bit_addr,
   output logic o_stack_pop
);
   alu_state_t state;
   alu_state_t next_state;
   alu_op_t op;
   logic [31:0] operand;
   logic [5:0] bits_left;
   logic [5:0] bit_idx;
   logic [31:0] result;

   // Timing of the far side
   // Each request stands for one cycle on its strobe
   // The answer must stand in that same cycle
   // It is taken at the edge that ends the request cycle
   // Word form: start, one fetch, then done
   // Double from memory: low word, then high word at address plus one
   // Immediate form: no fetch at all, done one cycle after start
   // Bit run: one bit per cycle, lowest bit first
   // Stack form: top level sampled as the pop strobe rises, then done one cycle later
   // Limitation: no wait states on any far-side answer
   // A slow memory needs a hold-off added in front of this unit
   // Trade-off: bit runs cost one cycle per bit, no wide port needed
   // Counts outside 1..32 are clamped rather than refused
   // Starts while busy are ignored, so the sequencer must watch busy
   // Loads only land while idle and without a start
   // Flags move only at done, never on a load
   // Freeze: clock enable low holds every state and output

   // Count clamped into the legal 1..32 range
   wire logic [5:0] run_len = (i_count < ALU_CNT_MIN) ? ALU_CNT_MIN :
      (i_count > ALU_CNT_MAX) ? ALU_CNT_MAX : i_count;
   wire logic is_word = (op == ALU_OP_WORD);
   wire logic [31:0] word_result = {16'h0000, o_acc[15:0] & operand[15:0]};
   wire logic [31:0] wide_result = o_acc & operand;

   // Next state
   // Undefined opcodes fall back to idle, so nothing is fetched for them
   // Bit run leaves when the last counted bit is being taken
   // Done lasts exactly one cycle before returning to idle
   always_comb
   begin
      next_state = state;
      case (state)
         ALU_ST_IDLE:
         begin
            if (i_start)
            begin
               case (i_op)
                  ALU_OP_WORD: next_state = ALU_ST_LOW;
                  ALU_OP_DOUBLE_MEM: next_state = ALU_ST_LOW;
                  ALU_OP_DOUBLE_IMM: next_state = ALU_ST_DONE;
                  ALU_OP_RUN: next_state = ALU_ST_BITS;
                  ALU_OP_STACK: next_state = ALU_ST_POP;
                  default: next_state = ALU_ST_IDLE;
               endcase
            end
         end
         ALU_ST_LOW: next_state = is_word ? ALU_ST_DONE : ALU_ST_HIGH;
         ALU_ST_HIGH: next_state = ALU_ST_DONE;
         ALU_ST_BITS: next_state = (bits_left == 6'h01) ? ALU_ST_DONE : ALU_ST_BITS;
         ALU_ST_POP: next_state = ALU_ST_DONE;
         ALU_ST_DONE: next_state = ALU_ST_IDLE;
         default: next_state = ALU_ST_IDLE;
      endcase
   end

   assign result = is_word ? word_result : wide_result;

   // State and operand gathering
   // Memory answer is taken at the edge ending its request cycle
   // Operand starts cleared, so short bit runs leave high bits zero
   // Immediate operand is loaded whole at the start edge
   // Bit index wraps at 32, which the count clamp never reaches
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         state <= ALU_ST_IDLE;
         op <= ALU_OP_WORD;
         operand <= ALU_ACC_RST;
         bits_left <= 6'h00;
         bit_idx <= 6'h00;
      end
      else if (i_ce)
      begin
         state <= next_state;
         if (state == ALU_ST_IDLE && i_start)
         begin
            op <= alu_op_t'(i_op);
            operand <= (i_op == ALU_OP_DOUBLE_IMM) ? i_imm : ALU_ACC_RST;
            bits_left <= run_len;
            bit_idx <= 6'h00;
         end
         if (state == ALU_ST_LOW)
            operand[15:0] <= i_mem_rdata;
         if (state == ALU_ST_HIGH)
            operand[31:16] <= i_mem_rdata;
         if (state == ALU_ST_BITS)
         begin
            operand[bit_idx[4:0]] <= i_bit_rdata;
            bit_idx <= bit_idx + 6'h01;
            bits_left <= bits_left - 6'h01;
         end
         if (state == ALU_ST_POP)
            operand <= i_stack_top;
      end
   end

   // Accumulator, flags and handshake outputs, all registered
   // Read strobes come from next state, so they rise with the state change
   // Hazard: a flag written at done stays valid until the next done
   // Word form keeps the sign flag; only zero is defined for it
   // Addresses step after each taken bit and after the low word only, never before
   // Pop strobe is one cycle wide, so the stack moves exactly once
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         o_acc <= ALU_ACC_RST;
         o_zero_result_flag <= 1'b0;
         o_negative_result_flag <= 1'b0;
         o_done <= 1'b0;
         o_busy <= 1'b0;
         o_mem_rd <= 1'b0;
         o_mem_addr <= 16'h0000;
         o_bit_rd <= 1'b0;
         o_bit_addr <= 16'h0000;
         o_stack_pop <= 1'b0;
      end
      else if (i_ce)
      begin
         o_done <= 1'b0;
         o_stack_pop <= 1'b0;
         o_busy <= (next_state != ALU_ST_IDLE);
         o_mem_rd <= (next_state == ALU_ST_LOW) || (next_state == ALU_ST_HIGH);
         o_bit_rd <= (next_state == ALU_ST_BITS);
         if (state == ALU_ST_IDLE && i_start)
         begin
            o_mem_addr <= i_addr;
            o_bit_addr <= i_addr;
         end
         if (state == ALU_ST_LOW)
            o_mem_addr <= o_mem_addr + 16'h0001;
         if (state == ALU_ST_BITS)
            o_bit_addr <= o_bit_addr + 16'h0001;
         if (state == ALU_ST_POP)
            o_stack_pop <= 1'b1;
         // Load path from the sequencer, idle only
         if (state == ALU_ST_IDLE && i_load && !i_start)
            o_acc <= i_load_value;
         if (state == ALU_ST_DONE)
         begin
            o_acc <= result;
            o_done <= 1'b1;
            o_zero_result_flag <= (result == ALU_ACC_RST);
            if (!is_word)
               o_negative_result_flag <= result[ALU_MSB];
         end
      end
   end
endmodule : alu_and_unit

// >>> verilog/alu_pkg.sv
// Package for the accumulator AND unit: widths, opcodes, states, resets.
// Assumes a single 40 MHz core clock and synchronous reset in the sequencer.
package alu_pkg;
   localparam int ALU_ACC_W = 32;
   localparam int ALU_WORD_W = 16;
   localparam int ALU_ADDR_W = 16;
   localparam int ALU_CNT_W = 6;
   localparam logic [5:0] ALU_CNT_MIN = 6'h01;
   localparam logic [5:0] ALU_CNT_MAX = 6'h20;
   localparam logic [31:0] ALU_ACC_RST = 32'h00000000;
   localparam int ALU_MSB = 31;

   // Operation select
   typedef enum logic [2:0] {
      ALU_OP_WORD = 3'h0,
      ALU_OP_DOUBLE_MEM = 3'h1,
      ALU_OP_DOUBLE_IMM = 3'h2,
      ALU_OP_RUN = 3'h3,
      ALU_OP_STACK = 3'h4
   } alu_op_t;

   // Sequencer states
   typedef enum logic [2:0] {
      ALU_ST_IDLE = 3'h0,
      ALU_ST_LOW = 3'h1,
      ALU_ST_HIGH = 3'h2,
      ALU_ST_BITS = 3'h3,
      ALU_ST_POP = 3'h4,
      ALU_ST_DONE = 3'h5
   } alu_state_t;
endpackage : alu_pkg

// >>> dv/alu_and_asserts.sv
// Port checker for the AND unit, bound below.
// Assumes i_ce stays high while operations run.
module alu_and_asserts
   import alu_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_start,
   input wire logic [2:0] i_op,
   input wire logic [31:0] i_imm,
   input wire logic i_load,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic [31:0] o_acc,
   input wire logic o_zero_result_flag,
   input wire logic o_negative_result_flag,
   input wire logic o_mem_rd,
   input wire logic o_stack_pop
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] op_q;
   wire logic tk = i_start && !o_busy;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   // Op in flight, so done-time checks know the form
   always_ff @(posedge i_core_clk)
      if (tk) op_q <= i_op;
   chk_word_fetch:
   assert property (tk && i_op == ALU_OP_WORD |=> o_mem_rd ##2 o_done) else $error("fetch");
   chk_word_upper:
   assert property (o_done && op_q == ALU_OP_WORD |-> o_acc[31:16] == 16'h0000) else $error("upper");
   chk_zero_flag:
   assert property (o_done |-> o_zero_result_flag == (o_acc == 32'h0)) else $error("zero");
   chk_neg_flag:
   assert property (o_done && op_q != ALU_OP_WORD |-> o_negative_result_flag == o_acc[31])
      else $error("neg");
   chk_word_neg_kept:
   assert property (tk && i_op == ALU_OP_WORD |=> $stable(o_negative_result_flag)[*3])
      else $error("neg moved");
   chk_imm_and:
   assert property (tk && i_op == ALU_OP_DOUBLE_IMM |-> ##2 o_done
      && o_acc == ($past(o_acc, 2) & $past(i_imm, 2))) else $error("imm");
   chk_pop_timing:
   assert property (tk && i_op == ALU_OP_STACK |-> ##2 o_stack_pop ##1 o_done) else $error("pop");
   chk_flags_hold:
   assert property ($changed(o_zero_result_flag) |-> o_done || $past(i_load)) else $error("hold");
endmodule : alu_and_asserts
bind alu_and_unit alu_and_asserts alu_and_asserts_inst (.*);

// >>> dv/alu_far_model.sv
// Far side: word memory, bit memory, three-level stack.
// Assumes the unit samples the answer at the edge that ends its request cycle.
module alu_far_model
(
   input wire logic i_core_clk,
   input wire logic i_mem_rd,
   input wire logic [15:0] i_mem_addr,
   input wire logic i_bit_rd,
   input wire logic [15:0] i_bit_addr,
   input wire logic i_stack_pop,
   output logic [15:0] o_mem_rdata,
   output logic o_bit_rdata,
   output logic [31:0] o_stack_top
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] stk [3] = '{32'h8421F0F1, 32'h00000000, 32'hFFFFFFFF};
   logic [15:0] junk_word = 16'hA5C3;
   logic junk_bit = 1'h0;
   assign o_stack_top = stk[0];
   // Answer stands in the request cycle; junk outside it, so stray sampling shows up
   assign o_mem_rdata = i_mem_rd ? (i_mem_addr ^ 16'h5A3C) : junk_word;
   assign o_bit_rdata = i_bit_rd ? (i_bit_addr[0] ~^ i_bit_addr[2]) : junk_bit;
   always @(posedge i_core_clk)
   begin
      junk_word <= ~junk_word;
      junk_bit <= ~junk_bit;
      if (i_stack_pop)
         stk <= '{stk[1], stk[2], 32'hFFFFFFFF};
   end
endmodule : alu_far_model

// >>> dv/tb_top.sv
// Bench: unit, far side model, bound checker.
// Assumes the checker binds itself.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import alu_pkg::*;
   logic i_core_clk = 1'h0, i_srst = 1'h1, i_start = 1'h0, i_load = 1'h0, i_bit_rdata;
   logic [2:0] i_op = 3'h0;
   logic [5:0] i_count = 6'h01;
   logic [15:0] i_addr = 16'h0000, i_mem_rdata, o_mem_addr, o_bit_addr;
   logic [31:0] i_imm = 32'h0, i_load_value = 32'h0, i_stack_top, o_acc, e;
   logic o_busy, o_done, o_zero_result_flag, o_negative_result_flag, o_mem_rd, o_bit_rd;
   logic o_stack_pop;
   int bad_count = 0, checks = 0;
   always #12.5 i_core_clk = ~i_core_clk;
   alu_and_unit alu_and_unit_inst (.*, .i_ce(1'h1));
   alu_far_model alu_far_model_inst (.i_core_clk, .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
      .i_bit_rd(o_bit_rd), .i_bit_addr(o_bit_addr), .i_stack_pop(o_stack_pop),
      .o_mem_rdata(i_mem_rdata), .o_bit_rdata(i_bit_rdata), .o_stack_top(i_stack_top));
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x)
      begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   // Optional load, one start, bounded wait for done
   task automatic run(input logic ld, input logic [31:0] a, input logic [2:0] o,
      input logic [31:0] v, input logic [5:0] n);
      @(posedge i_core_clk);
      i_load <= ld;
      i_load_value <= a;
      i_op <= o;
      i_addr <= v[15:0];
      i_imm <= v;
      i_count <= n;
      @(posedge i_core_clk);
      i_load <= 1'h0;
      i_start <= 1'h1;
      @(posedge i_core_clk);
      i_start <= 1'h0;
      @(negedge i_core_clk);
      // Looked at mid-cycle, where the done pulse is settled
      for (int k = 0; k < 40 && o_done !== 1'h1; k++)
         @(negedge i_core_clk);
      if (o_done !== 1'h1)
      begin
         bad_count++;
         give_verdict();
      end
   endtask : run
   initial
   begin
      repeat (3) @(posedge i_core_clk);
      i_srst <= 1'h0;
      @(negedge i_core_clk);
      chk(o_acc, ALU_ACC_RST);
      // Double forms; the sign-bit result feeds the word test
      run(1'h1, 32'hFFFF0FFF, ALU_OP_DOUBLE_MEM, 32'h20, 6'h01);
      chk(o_acc, {16'h0021 ^ 16'h5A3C, 16'h0020 ^ 16'h5A3C} & 32'hFFFF0FFF);
      run(1'h1, 32'hFFFFFFFF, ALU_OP_DOUBLE_IMM, 32'h80000001, 6'h01);
      chk(o_negative_result_flag, 32'h1);
      $display("double done");
      // Word: zero result must keep the sign flag
      run(1'h0, 32'h0, ALU_OP_WORD, 32'h10, 6'h01);
      chk({o_negative_result_flag, o_zero_result_flag}, 32'h3);
      run(1'h1, 32'hFFFFFFFF, ALU_OP_WORD, 32'h10, 6'h01);
      chk(o_acc, 32'h00005A2C);
      $display("word done");
      // Bit runs at both count limits
      for (int n = 1; n <= 32; n += 31)
      begin
         e = 32'h0;
         for (int k = 0; k < n; k++)
            e[k] = k[0] ~^ k[2];
         run(1'h1, 32'hFFFFFFFF, ALU_OP_RUN, 32'h40, n[5:0]);
         chk(o_acc, e);
      end
      $display("run done");
      // Two pops: second level must have moved up
      run(1'h1, 32'hFFFFFFFF, ALU_OP_STACK, 32'h0, 6'h01);
      chk(o_acc, 32'h8421F0F1);
      run(1'h0, 32'h0, ALU_OP_STACK, 32'h0, 6'h01);
      chk(o_zero_result_flag, 32'h1);
      $display("stack done");
      give_verdict();
   end
endmodule : tb_top
